// ### core/sldrv_pkg.sv
// Shared constants and types of the segment LCD scan driver
`default_nettype none

package sldrv_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Geometry of the glass and of the display memory
   localparam int SEG_N = 28;
   localparam int COM_N = 4;
   localparam int MEM_BYTES = 14;
   localparam int MEM_BITS = 112;
   localparam int ADDR_W = 4;
   localparam int GPIO_N = 8;
   // Lowest segment line that can be handed over to a port pin
   localparam int GPIO_BASE = 20;
   localparam int RATE_W = 8;
   localparam int TRIM_W = 4;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] MEM_RESET = 8'h00;
   localparam logic [RATE_W-1:0] RATE_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Timing: one base tick of the slot timer
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SLOT_BASE_NS = 8000;
   localparam int SLOT_BASE_CYC = (SLOT_BASE_NS * 1000) / CLK_PERIOD_PS;
   localparam int BASE_W = 11;
   localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(SLOT_BASE_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // Display modes and scan states
   typedef enum logic [1:0] {
      SLDRV_STATIC = 2'b00,
      SLDRV_DUTY2 = 2'b01,
      SLDRV_DUTY3 = 2'b10,
      SLDRV_DUTY4 = 2'b11
   } sldrv_mode_e;

   typedef enum logic [0:0] {
      SLDRV_IDLE = 1'b0,
      SLDRV_SCAN = 1'b1
   } sldrv_state_e;

endpackage : sldrv_pkg

`default_nettype wire

// ### core/sldrv_mem_if.sv
// Carrier between the scan controller and the display memory
`default_nettype none

interface sldrv_mem_if;
   import sldrv_pkg::*;

   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [7:0] rd_data;
   logic rd_valid;
   logic snap;
   logic [MEM_BITS-1:0] scan_bits;

   modport ctl (
      output wr_en, wr_addr, wr_data, rd_en, rd_addr, snap,
      input rd_data, rd_valid, scan_bits
   );

   modport mem (
      input wr_en, wr_addr, wr_data, rd_en, rd_addr, snap,
      output rd_data, rd_valid, scan_bits
   );

endinterface : sldrv_mem_if

`default_nettype wire

// ### core/sldrv_mem.sv
// Fourteen-byte display memory with software port and frame snapshot
`default_nettype none

module sldrv_mem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   sldrv_mem_if.mem m
);
   import sldrv_pkg::*;

   logic [7:0] mem_q [MEM_BYTES];
   logic [7:0] next_mem [MEM_BYTES];
   logic [7:0] rd_data_q;
   logic [7:0] next_rd_data;
   logic rd_valid_q;
   logic next_rd_valid;
   logic [MEM_BITS-1:0] scan_q;
   logic [MEM_BITS-1:0] next_scan;

   ////////////////////////////////////////////////////////////////////////
   // Every byte is plain storage, used by the glass or not
   always_comb begin
      for (int b = 0; b < MEM_BYTES; b++) begin
         next_mem[b] = mem_q[b];
      end
      if (m.wr_en && (int'(m.wr_addr) < MEM_BYTES)) begin
         next_mem[m.wr_addr] = m.wr_data;
      end
      next_rd_valid = m.rd_en;
      next_rd_data = rd_data_q;
      if (m.rd_en) begin
         // Unmapped addresses read as zero
         next_rd_data = (int'(m.rd_addr) < MEM_BYTES) ?
                        mem_q[m.rd_addr] : 8'h00;
      end
      // Snapshot once per frame so the glass never sees a torn update
      next_scan = scan_q;
      if (m.snap) begin
         for (int b = 0; b < MEM_BYTES; b++) begin
            next_scan[b*8 +: 8] = mem_q[b];
         end
      end
   end

   // Registers, frozen while the clock enable is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int b = 0; b < MEM_BYTES; b++) begin
            mem_q[b] <= MEM_RESET;
         end
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
         scan_q <= '0;
      end else if (ce) begin
         mem_q <= next_mem;
         rd_data_q <= next_rd_data;
         rd_valid_q <= next_rd_valid;
         scan_q <= next_scan;
      end
   end

   assign m.rd_data = rd_data_q;
   assign m.rd_valid = rd_valid_q;
   assign m.scan_bits = scan_q;

endmodule : sldrv_mem

`default_nettype wire

// ### core/sldrv_top.sv
// Segment LCD scan driver: scan timing, waveform outputs, port pin sharing
`default_nettype none

module sldrv_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic enable,
   input wire sldrv_pkg::sldrv_mode_e mode,
   input wire logic [sldrv_pkg::RATE_W-1:0] frame_rate,
   input wire logic [sldrv_pkg::TRIM_W-1:0] contrast,
   input wire logic ext_bias,
   input wire logic [sldrv_pkg::GPIO_N-1:0] gpio_sel,
   input wire logic [sldrv_pkg::GPIO_N-1:0] gpio_out,
   input wire logic [sldrv_pkg::GPIO_N-1:0] gpio_dir,
   output logic [sldrv_pkg::GPIO_N-1:0] gpio_in,
   input wire logic mem_wr_en,
   input wire logic [sldrv_pkg::ADDR_W-1:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data,
   input wire logic mem_rd_en,
   input wire logic [sldrv_pkg::ADDR_W-1:0] mem_rd_addr,
   output logic [7:0] mem_rd_data,
   output logic mem_rd_valid,
   input wire logic [sldrv_pkg::SEG_N-1:0] lcd_segment_in,
   output logic [sldrv_pkg::SEG_N-1:0] lcd_segment_lines,
   output logic [sldrv_pkg::SEG_N-1:0] lcd_segment_oe,
   output logic [sldrv_pkg::COM_N-1:0] lcd_backplane_lines,
   output logic [sldrv_pkg::COM_N-1:0] lcd_backplane_sel,
   output logic bias_on,
   output logic bias_third,
   output logic divider_int_en,
   output logic [sldrv_pkg::TRIM_W-1:0] contrast_trim,
   output logic scan_busy,
   output logic frame_tick
);
   import sldrv_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Highest common index that a mode scans
   function automatic logic [1:0] last_com(input sldrv_mode_e md);
      logic [1:0] r;
      case (md)
         SLDRV_STATIC: r = 2'h0;
         SLDRV_DUTY2: r = 2'h1;
         SLDRV_DUTY3: r = 2'h2;
         SLDRV_DUTY4: r = 2'h3;
         default: r = 2'h0;
      endcase
      return r;
   endfunction : last_com

   // Memory bit of segment s on common c: bit s*4+c, two segments a byte
   function automatic logic seg_bit(input logic [MEM_BITS-1:0] d,
                                    input int s, input logic [1:0] c);
      return d[s*COM_N + int'(c)];
   endfunction : seg_bit

   ////////////////////////////////////////////////////////////////////////
   // Display memory

   sldrv_mem_if mif ();

   sldrv_mem u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .m(mif.mem)
   );

   logic snap;

   assign mif.wr_en = mem_wr_en;
   assign mif.wr_addr = mem_wr_addr;
   assign mif.wr_data = mem_wr_data;
   assign mif.rd_en = mem_rd_en;
   assign mif.rd_addr = mem_rd_addr;
   assign mif.snap = snap;
   assign mem_rd_data = mif.rd_data;
   assign mem_rd_valid = mif.rd_valid;

   ////////////////////////////////////////////////////////////////////////
   // Scan sequencer state

   sldrv_state_e state;
   sldrv_state_e next_state;
   logic [BASE_W-1:0] base_cnt;
   logic [BASE_W-1:0] next_base_cnt;
   logic [RATE_W-1:0] rate_cnt;
   logic [RATE_W-1:0] next_rate_cnt;
   logic [1:0] com_idx;
   logic [1:0] next_com_idx;
   logic phase;
   logic next_phase;
   sldrv_mode_e act_mode;
   sldrv_mode_e next_act_mode;
   logic next_frame_tick;
   logic base_tick;
   logic slot_end;

   assign base_tick = (base_cnt == BASE_LAST);
   // Slot length is (frame_rate+1) base ticks
   assign slot_end = base_tick && (rate_cnt == frame_rate);

   // Each common slot has two phases so the glass sees no DC
   always_comb begin
      next_state = state;
      next_base_cnt = base_cnt;
      next_rate_cnt = rate_cnt;
      next_com_idx = com_idx;
      next_phase = phase;
      next_act_mode = act_mode;
      next_frame_tick = 1'b0;
      snap = 1'b0;
      case (state)
         SLDRV_IDLE: begin
            if (enable) begin
               next_state = SLDRV_SCAN;
               next_base_cnt = '0;
               next_rate_cnt = RATE_RESET;
               next_com_idx = 2'h0;
               next_phase = 1'b0;
               next_act_mode = mode;
               snap = 1'b1;
            end
         end
         SLDRV_SCAN: begin
            if (!enable) begin
               next_state = SLDRV_IDLE;
               next_base_cnt = '0;
               next_rate_cnt = RATE_RESET;
               next_com_idx = 2'h0;
               next_phase = 1'b0;
            end else begin
               next_base_cnt = base_tick ? '0 : base_cnt + 1'b1;
               if (base_tick) begin
                  next_rate_cnt = slot_end ? RATE_RESET :
                                  rate_cnt + 1'b1;
               end
               if (slot_end) begin
                  if (!phase) begin
                     next_phase = 1'b1;
                  end else begin
                     next_phase = 1'b0;
                     if (com_idx == last_com(act_mode)) begin
                        // Mode and memory picked up only at frame edges
                        next_com_idx = 2'h0;
                        next_act_mode = mode;
                        snap = 1'b1;
                        next_frame_tick = 1'b1;
                     end else begin
                        next_com_idx = com_idx + 2'h1;
                     end
                  end
               end
            end
         end
         default: begin
            next_state = SLDRV_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SLDRV_IDLE;
         base_cnt <= '0;
         rate_cnt <= RATE_RESET;
         com_idx <= 2'h0;
         phase <= 1'b0;
         act_mode <= SLDRV_STATIC;
         frame_tick <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         base_cnt <= next_base_cnt;
         rate_cnt <= next_rate_cnt;
         com_idx <= next_com_idx;
         phase <= next_phase;
         act_mode <= next_act_mode;
         frame_tick <= next_frame_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port pin input synchroniser

   logic [GPIO_N-1:0] gpio_meta;
   logic [GPIO_N-1:0] next_gpio_meta;
   logic [GPIO_N-1:0] next_gpio_in;

   // Pins are asynchronous, so two flops before anyone looks
   always_comb begin
      next_gpio_meta = lcd_segment_in[GPIO_BASE +: GPIO_N];
      next_gpio_in = gpio_meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gpio_meta <= '0;
         gpio_in <= '0;
      end else if (ce) begin
         gpio_meta <= next_gpio_meta;
         gpio_in <= next_gpio_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Waveform and bias outputs

   logic scanning;
   logic [SEG_N-1:0] next_seg;
   logic [SEG_N-1:0] next_seg_oe;
   logic [COM_N-1:0] next_bp;
   logic [COM_N-1:0] next_bp_sel;
   logic next_bias_on;
   logic next_bias_third;
   logic next_div_int;
   logic [TRIM_W-1:0] next_trim;

   assign scanning = (state == SLDRV_SCAN);

   // Selected common swings with the phase; others sit at mid bias
   always_comb begin
      next_seg = '0;
      next_seg_oe = '1;
      next_bp = '0;
      next_bp_sel = '0;
      for (int s = 0; s < SEG_N; s++) begin
         if (scanning) begin
            // Lit: opposite the common, so the pair sees full swing
            next_seg[s] = seg_bit(mif.scan_bits, s, com_idx) ?
                          ~phase : phase;
         end
      end
      for (int g = 0; g < GPIO_N; g++) begin
         if (gpio_sel[g]) begin
            next_seg[GPIO_BASE + g] = gpio_out[g];
            next_seg_oe[GPIO_BASE + g] = gpio_dir[g];
         end
      end
      for (int c = 0; c < COM_N; c++) begin
         if (scanning && (c <= int'(last_com(act_mode)))) begin
            next_bp_sel[c] = (2'(c) == com_idx);
            next_bp[c] = (2'(c) == com_idx) ? phase : 1'b0;
         end
      end
      next_bias_on = scanning;
      next_bias_third = scanning && ((act_mode == SLDRV_DUTY3) ||
                        (act_mode == SLDRV_DUTY4));
      // External resistors replace the internal ladder entirely
      next_div_int = scanning && !ext_bias;
      next_trim = next_div_int ? contrast : '0;
   end

   // Data outputs all leave from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lcd_segment_lines <= '0;
         lcd_segment_oe <= '1;
         lcd_backplane_lines <= '0;
         lcd_backplane_sel <= '0;
         bias_on <= 1'b0;
         bias_third <= 1'b0;
         divider_int_en <= 1'b0;
         contrast_trim <= '0;
      end else if (ce) begin
         lcd_segment_lines <= next_seg;
         lcd_segment_oe <= next_seg_oe;
         lcd_backplane_lines <= next_bp;
         lcd_backplane_sel <= next_bp_sel;
         bias_on <= next_bias_on;
         bias_third <= next_bias_third;
         divider_int_en <= next_div_int;
         contrast_trim <= next_trim;
      end
   end

   assign scan_busy = scanning;

endmodule : sldrv_top

`default_nettype wire

// ### testbench/sldrv_props.sv
// Port-level assertions of the segment LCD scan driver
`default_nettype none

module sldrv_props import sldrv_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic enable,
   input wire logic ext_bias,
   input wire logic [sldrv_pkg::GPIO_N-1:0] gpio_sel,
   input wire logic [sldrv_pkg::GPIO_N-1:0] gpio_out,
   input wire logic [sldrv_pkg::GPIO_N-1:0] gpio_dir,
   input wire logic mem_rd_en,
   input wire logic [sldrv_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic [7:0] mem_rd_data,
   input wire logic mem_rd_valid,
   input wire logic [sldrv_pkg::SEG_N-1:0] lcd_segment_lines,
   input wire logic [sldrv_pkg::SEG_N-1:0] lcd_segment_oe,
   input wire logic [sldrv_pkg::COM_N-1:0] lcd_backplane_sel,
   input wire logic bias_on,
   input wire logic divider_int_en,
   input wire logic [sldrv_pkg::TRIM_W-1:0] contrast_trim,
   input wire logic scan_busy,
   input wire logic frame_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   // One domain, so one clock and one reset for all checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////
   property p_rd_answer;
      ce && mem_rd_en |=> mem_rd_valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read lost");
   property p_unmapped;
      ce && mem_rd_en && mem_rd_addr >= 4'hE |=> mem_rd_data == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   // Two commons in full swing at once would light wrong pairs
   property p_one_com;
      $onehot0(lcd_backplane_sel);
   endproperty
   a_one_com: assert property (p_one_com) else $error("two commons");
   property p_start;
      ce && enable && !scan_busy |=> scan_busy;
   endproperty
   a_start: assert property (p_start) else $error("scan not started");
   property p_stop;
      (ce && !enable)[*2] |=>
         !scan_busy && !bias_on && lcd_backplane_sel == 4'h0;
   endproperty
   a_stop: assert property (p_stop) else $error("drive while off");
   property p_trim;
      !divider_int_en |-> contrast_trim == 4'h0;
   endproperty
   a_trim: assert property (p_trim) else $error("trim without divider");
   property p_ext;
      (ce && scan_busy && $stable(ext_bias))[*3] |->
         divider_int_en != ext_bias;
   endproperty
   a_ext: assert property (p_ext) else $error("divider select");
   property p_gpio_oe;
      ce |=> lcd_segment_oe ==
         {~($past(gpio_sel) & ~$past(gpio_dir)), 20'hF_FFFF};
   endproperty
   a_gpio_oe: assert property (p_gpio_oe) else $error("port enable");
   property p_gpio_out;
      ce |=> ((lcd_segment_lines[27:20] ^ $past(gpio_out))
         & $past(gpio_sel) & $past(gpio_dir)) == 8'h00;
   endproperty
   a_gpio_out: assert property (p_gpio_out) else $error("port value");
   property p_tick;
      ce && frame_tick |=> !frame_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick too long");

endmodule : sldrv_props

bind sldrv_top sldrv_props chk_u (.clk, .rst_n, .ce, .enable, .ext_bias,
   .gpio_sel, .gpio_out, .gpio_dir, .mem_rd_en, .mem_rd_addr, .mem_rd_data,
   .mem_rd_valid, .lcd_segment_lines, .lcd_segment_oe, .lcd_backplane_sel,
   .bias_on, .divider_int_en, .contrast_trim, .scan_busy, .frame_tick);

`default_nettype wire

// ### testbench/sldrv_glass.sv
// Passive glass model: records which segment-common pairs were energised
`default_nettype none

module sldrv_glass import sldrv_pkg::*; (
   input wire logic clk,
   input wire logic clr,
   input wire logic [sldrv_pkg::SEG_N-1:0] seg,
   input wire logic [sldrv_pkg::COM_N-1:0] com,
   input wire logic [sldrv_pkg::COM_N-1:0] com_sel,
   output logic [sldrv_pkg::MEM_BITS-1:0] lit,
   output logic [sldrv_pkg::COM_N-1:0] seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // Mid-bias commons never light; sticky so one frame shows every pair
   always_ff @(posedge clk) begin
      if (clr) begin
         lit <= '0;
         seen <= '0;
      end else begin
         seen <= seen | com_sel;
         for (int s = 0; s < SEG_N; s++) begin
            for (int c = 0; c < COM_N; c++) begin
               if (com_sel[c] && (seg[s] ^ com[c])) begin
                  lit[s*COM_N+c] <= 1'b1;
               end
            end
         end
      end
   end
endmodule : sldrv_glass

`default_nettype wire

// ### testbench/sldrv_top_tb.sv
// Self-checking bench of the segment LCD scan driver
`default_nettype none

module sldrv_top_tb import sldrv_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, ce, enable, ext_bias, mem_wr_en, mem_rd_en, clr;
   sldrv_mode_e mode;
   logic [RATE_W-1:0] frame_rate;
   logic [TRIM_W-1:0] contrast, contrast_trim;
   logic [GPIO_N-1:0] gpio_sel, gpio_out, gpio_dir, gpio_in, ext_pin;
   logic [ADDR_W-1:0] mem_wr_addr, mem_rd_addr;
   logic [7:0] mem_wr_data, mem_rd_data;
   logic [SEG_N-1:0] seg_in, seg, seg_oe;
   logic [COM_N-1:0] com, com_sel, seen;
   logic [MEM_BITS-1:0] lit, shadow;
   logic mem_rd_valid, bias_on, bias_third, div_en, scan_busy, frame_tick;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   sldrv_top dut_u (.clk, .rst_n, .ce, .enable, .mode, .frame_rate,
      .contrast, .ext_bias, .gpio_sel, .gpio_out, .gpio_dir, .gpio_in,
      .mem_wr_en, .mem_wr_addr, .mem_wr_data, .mem_rd_en, .mem_rd_addr,
      .mem_rd_data, .mem_rd_valid, .lcd_segment_in(seg_in),
      .lcd_segment_lines(seg), .lcd_segment_oe(seg_oe),
      .lcd_backplane_lines(com), .lcd_backplane_sel(com_sel), .bias_on,
      .bias_third, .divider_int_en(div_en), .contrast_trim, .scan_busy,
      .frame_tick);
   sldrv_glass glass_u (.clk, .clr, .seg, .com, .com_sel, .lit, .seen);
   // Released port lines show the outside level, never the last drive
   assign seg_in = (seg & seg_oe) | ({ext_pin, 20'h0_0000} & ~seg_oe);

   ////////////////////////////////////////
   // Hang guard: four scans of two frames need about 88000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         fails++;
         $display("CHECK FAILED %0t timeout", $time);
         complete_run();
      end
   end

   task automatic chk_val(input logic [127:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, what);
      end
   endtask : chk_val

   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      mem_wr_en = 1'b1;
      mem_wr_addr = a;
      mem_wr_data = d;
      @(negedge clk);
      mem_wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(negedge clk);
      mem_rd_en = 1'b1;
      mem_rd_addr = a;
      @(negedge clk);
      mem_rd_en = 1'b0;
      chk_val(mem_rd_valid, 1'b1, "read valid");
      chk_val(mem_rd_data, exp, "read data");
   endtask : rd

   // Bounded wait for the end-of-frame pulse, counting cycles
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!frame_tick && n < 40000);
   endtask : wait_tick

   ////////////////////////////////////////
   task automatic t_reset();
      chk_val(seg_oe, {SEG_N{1'b1}}, "oe in reset");
      chk_val({scan_busy, bias_on, com_sel, com, seg}, '0,
         "reset drive");
      $display("test reset done");
   endtask : t_reset

   task automatic t_mem();
      for (int b = 0; b < 16; b++) begin
         wr(4'(b), 8'(b * 8'h35 + 8'h96));
         if (b < MEM_BYTES) shadow[8*b +: 8] = 8'(b * 8'h35 + 8'h96);
      end
      // Frozen clock enable must drop this write
      ce = 1'b0;
      wr(4'h0, 8'h00);
      ce = 1'b1;
      for (int b = 0; b < 16; b++) begin
         rd(4'(b), b < MEM_BYTES ? shadow[8*b +: 8] : 8'h00);
      end
      $display("test memory done");
   endtask : t_mem

   task automatic t_gpio();
      @(negedge clk);
      gpio_sel = 8'hFF;
      gpio_dir = 8'h0F;
      gpio_out = 8'hA5;
      ext_pin = 8'h3C;
      repeat (3) @(negedge clk);
      chk_val(seg_oe, {8'h0F, 20'hF_FFFF}, "port enables");
      chk_val(seg[23:20], 4'h5, "port drive");
      chk_val(gpio_in, 8'h35, "port input");
      gpio_sel = 8'h00;
      $display("test port pins done");
   endtask : t_gpio

   task automatic t_scan(input sldrv_mode_e m);
      logic [MEM_BITS-1:0] exp;
      logic [COM_N-1:0] used;
      int n;
      used = ~(4'hE << m);
      for (int i = 0; i < MEM_BITS; i++) begin
         exp[i] = shadow[i] && (i % 4 <= int'(m));
      end
      @(negedge clk);
      mode = m;
      ext_bias = m[0];
      frame_rate = (m == SLDRV_STATIC) ? 8'h01 : 8'h00;
      enable = 1'b1;
      wait_tick(n);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      wait_tick(n);
      chk_val(128'(n + 1), 128'((int'(frame_rate) + 1) * SLOT_BASE_CYC * 2
         * (int'(m) + 1)), "frame length");
      chk_val(lit, exp, "lit pairs");
      chk_val(seen, used, "commons used");
      chk_val({bias_on, bias_third}, {1'b1, m >= SLDRV_DUTY3}, "bias");
      chk_val({div_en, contrast_trim}, {~m[0], m[0] ? 4'h0 : contrast},
         "divider");
      enable = 1'b0;
      repeat (3) @(negedge clk);
      chk_val({scan_busy, bias_on, com_sel, com, seg}, '0,
         "idle drive");
      rd(4'h0, shadow[7:0]);
      $display("test scan mode %0d done", m);
   endtask : t_scan

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      {enable, ext_bias, mem_wr_en, mem_rd_en, clr} = 5'h01;
      mode = SLDRV_STATIC;
      frame_rate = 8'h00;
      contrast = 4'h9;
      {gpio_sel, gpio_out, gpio_dir, ext_pin} = 32'h0000_0000;
      {mem_wr_addr, mem_rd_addr, mem_wr_data} = 16'h0000;
      shadow = '0;
      repeat (2) @(negedge clk);
      t_reset();
      rst_n = 1'b1;
      t_mem();
      t_gpio();
      for (int m = 0; m < 4; m++) begin
         t_scan(sldrv_mode_e'(m));
      end
      complete_run();
   end
endmodule : sldrv_top_tb

`default_nettype wire
